// ### hw/ttt_timer.sv
`timescale 1ns/100ps
// Notes on behaviour
// - 24-bit down counter loaded from three preload bytes
// - counter clocked via divide-by-32 prescaler or direct
// - clock source system tick or external pin
// - zero reached sets the zero-detect flag
// - control byte selects reload, clock, prescaler, enable; pin bit stored but unused
// - active-low interrupt on decrement one to zero
// - top three control bits: interrupt and mode
// - registers decoded in timer address range
// - interrupt presented at priority level two
// - prescaler advances on falling system tick edge, or on rising external pin edge when that source is selected
// - restart reloads counter from preload automatically
// - sync on first rising edge of input
// - one is 2 kHz period, zero 1 kHz
module ttt_timer
    import ttt_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic [23:0]      bus_addr,
    input  wire logic             bus_wr,
    input  wire logic             bus_rd,
    input  wire logic [7:0]       bus_wdata,
    output logic [7:0]            bus_rdata,
    output logic                  bus_ack,
    input  wire logic             ext_timer_clock_in,
    input  wire logic             tape_in_line,
    output logic                  tape_out_line,
    output logic                  tape_out_oe_n,
    output logic                  timer_irq_out_n,
    output logic [2:0]            irq_level,
    output logic                  zero_detect_flag,
    output logic                  edge_valid,
    input  wire logic             edge_ready,
    output logic [CNT_W-1:0]      edge_count
);
    typedef struct packed {
        logic [7:0]            ctrl;
        logic [CNT_W-1:0]      preload;
        logic [CNT_W-1:0]      count;
        logic [PRESCALE_W-1:0] presc;
        logic [5:0]            tick_div;
        logic                  tick_q;
        logic [1:0]            ext_sync;
        logic                  ext_q;
        logic [1:0]            tape_sync;
        logic                  tape_q;
        logic                  synced;
        logic                  zdf;
        logic                  irq_n;
        logic                  out_line;
        logic [7:0]            rdata;
        logic                  ack;
        logic [2:0]            irq_lvl;
        logic                  out_oe_n;
    } ttt_s;

    ttt_s st_reg;
    ttt_s st_next;
    logic buf_in_ready;
    logic cap_valid;

    // address range check and offset within the timer window
    function automatic logic in_range(input logic [23:0] a);
        in_range = (a >= TIMER_BASE) && (a <= TIMER_LAST);
    endfunction

    function automatic logic [4:0] offs(input logic [23:0] a);
        logic [23:0] d;
        d = a - TIMER_BASE;
        offs = d[4:0];
    endfunction

    always_comb begin
        logic tick;
        logic src_edge;
        logic cnt_en;
        logic running;
        logic restart;
        logic tape_rise;
        logic [5:0] div_max;
        tick      = 1'b0;
        src_edge  = 1'b0;
        cnt_en    = 1'b0;
        restart   = 1'b0;
        tape_rise = 1'b0;
        div_max   = 6'(TICK_DIV - 1);
        running   = st_reg.ctrl[CTRL_ENABLE];
        st_next   = st_reg;
        st_next.ack = 1'b0;

        // 4 MHz system tick falling edge from a divider
        st_next.tick_div = (st_reg.tick_div == div_max) ? 6'h00
                           : st_reg.tick_div + 6'h01;
        st_next.tick_q = (st_reg.tick_div < 6'(TICK_DIV / 2));
        tick = st_reg.tick_q && !st_next.tick_q;

        // external clock and tape input synchronisers
        st_next.ext_sync = {st_reg.ext_sync[0], ext_timer_clock_in};
        st_next.ext_q    = st_reg.ext_sync[1];
        st_next.tape_sync = {st_reg.tape_sync[0], tape_in_line};
        st_next.tape_q    = st_reg.tape_sync[1];
        tape_rise = st_reg.tape_sync[1] && !st_reg.tape_q;

        // source select then optional prescaler
        src_edge = st_reg.ctrl[CTRL_EXT_CLK]
                   ? (st_reg.ext_sync[1] && !st_reg.ext_q)
                   : tick;
        if (running && src_edge) begin
            if (st_reg.ctrl[CTRL_NO_PRESC]) begin
                cnt_en = 1'b1;
            end else begin
                st_next.presc = st_reg.presc + 5'h01;
                cnt_en = (st_reg.presc == 5'h1f);
            end
        end

        // down counter with reload or rollover at zero
        if (cnt_en) begin
            if (st_reg.count == 24'h000001) begin
                st_next.zdf = 1'b1;
                if (st_reg.ctrl[CTRL_IRQ_EN_BIT]) begin
                    st_next.irq_n = 1'b0;
                end
            end
            if (st_reg.count == 24'h000000) begin
                st_next.count = st_reg.ctrl[CTRL_ROLLOVER]
                    ? 24'hffffff : st_reg.preload;
            end else begin
                st_next.count = st_reg.count - 24'h000001;
            end
        end

        // register writes; enable rising edge restarts
        if (bus_wr && in_range(bus_addr)) begin
            st_next.ack = 1'b1;
            unique case (offs(bus_addr))
                OFS_CTRL: begin
                    st_next.ctrl = bus_wdata;
                    restart = bus_wdata[CTRL_ENABLE] && !running;
                end
                OFS_PRE_HI:  st_next.preload[23:16] = bus_wdata;
                OFS_PRE_MID: st_next.preload[15:8]  = bus_wdata;
                OFS_PRE_LO:  st_next.preload[7:0]   = bus_wdata;
                OFS_STATUS: begin
                    // write one clears; a zero event this cycle wins
                    if (bus_wdata[0] && !(cnt_en
                        && st_reg.count == 24'h000001)) begin
                        st_next.zdf   = 1'b0;
                        st_next.irq_n = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (restart) begin
            st_next.count = st_reg.preload;
            st_next.presc = '0;
            st_next.zdf   = 1'b0;
            st_next.irq_n = 1'b1;
        end

        // registered level and pin enable for the outputs
        st_next.irq_lvl  = st_next.irq_n ? 3'h0 : IRQ_LEVEL;
        st_next.out_oe_n = 1'b0; // line always driven

        // register reads
        if (bus_rd && in_range(bus_addr)) begin
            st_next.ack = 1'b1;
            unique case (offs(bus_addr))
                OFS_CTRL:    st_next.rdata = st_reg.ctrl;
                OFS_PRE_HI:  st_next.rdata = st_reg.preload[23:16];
                OFS_PRE_MID: st_next.rdata = st_reg.preload[15:8];
                OFS_PRE_LO:  st_next.rdata = st_reg.preload[7:0];
                OFS_CNT_HI:  st_next.rdata = st_reg.count[23:16];
                OFS_CNT_MID: st_next.rdata = st_reg.count[15:8];
                OFS_CNT_LO:  st_next.rdata = st_reg.count[7:0];
                OFS_STATUS:  st_next.rdata = {7'h00, st_reg.zdf};
                default:     st_next.rdata = 8'h00;
            endcase
        end

        // tape output: bit 1 written at offset 1 drives line, pin function bit ignored
        if (bus_wr && in_range(bus_addr)
            && offs(bus_addr) == OFS_CTRL + 5'h01) begin
            st_next.out_line = bus_wdata[1];
        end

        // capture elapsed count (preload minus count) on input rising edges
        if (tape_rise) begin
            st_next.synced = 1'b1;
        end
        // a full buffer drops the capture
        cap_valid = tape_rise && st_reg.synced && running
                    && buf_in_ready;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.ctrl    <= CTRL_RST;
            st_reg.preload <= PRE_RST;
            st_reg.irq_n   <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // captured counts pass a two-entry buffer
    ttt_buf #(
        .WIDTH (CNT_W)
    ) u_buf (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_valid  (cap_valid),
        .in_ready  (buf_in_ready),
        .in_data   (st_reg.preload - st_reg.count),
        .out_valid (edge_valid),
        .out_ready (edge_ready),
        .out_data  (edge_count)
    );

    assign bus_rdata        = st_reg.rdata;
    assign bus_ack          = st_reg.ack;
    assign tape_out_line    = st_reg.out_line;
    assign tape_out_oe_n    = st_reg.out_oe_n;
    assign timer_irq_out_n  = st_reg.irq_n;
    assign irq_level        = st_reg.irq_lvl;
    assign zero_detect_flag = st_reg.zdf;
endmodule // ttt_timer

// ### inc/ttt_pkg.sv
package ttt_pkg;
    // counter geometry
    localparam int CNT_W          = 24;
    localparam int PRESCALE_W     = 5;
    localparam int BYTE_W         = 8;
    // control register field positions
    localparam int CTRL_IRQ_EN_BIT = 7;
    localparam int CTRL_MODE_HI    = 6;
    localparam int CTRL_MODE_LO    = 5;
    localparam int CTRL_ROLLOVER   = 4;
    localparam int CTRL_PIN_FN_BIT = 3;
    localparam int CTRL_EXT_CLK    = 2;
    localparam int CTRL_NO_PRESC   = 1;
    localparam int CTRL_ENABLE     = 0;
    // register offsets within the timer range
    localparam logic [4:0] OFS_CTRL    = 5'h00;
    localparam logic [4:0] OFS_PRE_HI  = 5'h06;
    localparam logic [4:0] OFS_PRE_MID = 5'h08;
    localparam logic [4:0] OFS_PRE_LO  = 5'h0a;
    localparam logic [4:0] OFS_CNT_HI  = 5'h0e;
    localparam logic [4:0] OFS_CNT_MID = 5'h10;
    localparam logic [4:0] OFS_CNT_LO  = 5'h12;
    localparam logic [4:0] OFS_STATUS  = 5'h14;
    localparam logic [23:0] TIMER_BASE = 24'h010021;
    localparam logic [23:0] TIMER_LAST = 24'h010035;
    // reset values
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [23:0] PRE_RST    = 24'h000000;
    // interrupt priority level presented to the processor
    localparam logic [2:0]  IRQ_LEVEL  = 3'h2;
    // rate of the timing source relative to sys_clk, and capture buffer depth
    localparam int SYS_CLK_MHZ    = 200;
    localparam int TICK_MHZ       = 4;
    localparam int TICK_DIV       = SYS_CLK_MHZ / TICK_MHZ;
    localparam int BUF_DEPTH      = 2;
endpackage

// ### hw/ttt_buf.sv
`timescale 1ns/100ps
// two-entry skid buffer for captured counts
module ttt_buf
    import ttt_pkg::*;
#(
    parameter int WIDTH = 24
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic [1:0]            cnt;
        logic                  in_ready;
        logic                  out_valid;
        logic [WIDTH-1:0]      out_data;
    } ttt_buf_s;

    ttt_buf_s st_reg;
    ttt_buf_s st_next;

    // push at tail, pop at head; data leave from registers
    always_comb begin
        logic push;
        logic pop;
        push = 1'b0;
        pop  = 1'b0;
        st_next = st_reg;
        push = in_valid && st_reg.in_ready;
        pop  = st_reg.out_valid && out_ready;
        if (pop) begin
            st_next.mem[0] = st_reg.mem[1];
        end
        if (push) begin
            if (pop) begin
                st_next.mem[st_reg.cnt - 2'h1] = in_data;
            end else begin
                st_next.mem[st_reg.cnt[0]] = in_data;
            end
        end
        st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
        st_next.in_ready  = (st_next.cnt != 2'(BUF_DEPTH));
        st_next.out_valid = (st_next.cnt != 2'h0);
        st_next.out_data  = st_next.mem[0];
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.in_ready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign in_ready  = st_reg.in_ready;
    assign out_valid = st_reg.out_valid;
    assign out_data  = st_reg.out_data;
endmodule // ttt_buf

// ### testbench/ttt_monitor.sv
`timescale 1ns/100ps
// port checks for the timer block
module ttt_monitor
    import ttt_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic [23:0] bus_addr,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic        bus_ack,
    input wire logic        tape_out_line,
    input wire logic        tape_out_oe_n,
    input wire logic        timer_irq_out_n,
    input wire logic [2:0]  irq_level,
    input wire logic        zero_detect_flag,
    input wire logic        edge_valid,
    input wire logic        edge_ready,
    input wire logic [23:0] edge_count
);
    logic in_rng;
    logic req;
    // access decode
    assign req = bus_wr | bus_rd;
    assign in_rng = bus_addr >= TIMER_BASE && bus_addr <= TIMER_LAST;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // bus answer timing
    chk_ack_in_range:
        assert property (req && in_rng |=> bus_ack) else $error("no ack");
    chk_ack_only_req:
        assert property (!(req && in_rng) |=> !bus_ack) else $error("ack");
    // interrupt level and cause
    chk_irq_level:
        assert property (!timer_irq_out_n |-> irq_level == 3'h2)
        else $error("irq level wrong");
    chk_irq_idle_level:
        assert property (timer_irq_out_n |-> irq_level == 3'h0)
        else $error("level without irq");
    chk_irq_has_flag:
        assert property (!timer_irq_out_n |-> zero_detect_flag)
        else $error("irq without flag");
    chk_flag_sticky:
        assert property (zero_detect_flag && !(bus_wr && in_rng)
            |=> zero_detect_flag) else $error("flag lost");
    // captures and tape line
    chk_edge_hold:
        assert property (edge_valid && !edge_ready
            |=> edge_valid && $stable(edge_count)) else $error("lost");
    chk_tape_steady:
        assert property (!(bus_wr && bus_addr == TIMER_BASE + 24'h1)
            |=> $stable(tape_out_line)) else $error("tape moved");
    chk_out_driving:
        assert property (!tape_out_oe_n) else $error("not driving");
endmodule // ttt_monitor

bind ttt_timer ttt_monitor i_mon (.sys_clk, .sys_rst, .bus_addr, .bus_wr,
    .bus_rd, .bus_ack, .tape_out_line, .tape_out_oe_n, .timer_irq_out_n,
    .irq_level, .zero_detect_flag, .edge_valid, .edge_ready, .edge_count);

// ### testbench/ttt_tape_model.sv
`timescale 1ns/100ps
// cassette player and recorder at the tape lines
module ttt_tape_model (
    input  wire logic sys_clk,
    input  wire logic tape_out_line,
    output logic      tape_in_line
);
    int unsigned n_out = 0;
    // plays n full tone periods of half h, idles low
    task automatic play(input int n, input int h);
        for (int i = 0; i < n; i++) begin
            repeat (h) @(negedge sys_clk);
            tape_in_line = 1'b1;
            repeat (h) @(negedge sys_clk);
            tape_in_line = 1'b0;
        end
    endtask
    // idle level and recorded rising edges
    initial tape_in_line = 1'b0;
    always @(posedge tape_out_line) n_out++;
endmodule // ttt_tape_model

// ### testbench/tb_top.sv
`timescale 1ns/100ps
// bench for the tape tone timer
module tb_top
    import ttt_pkg::*;
();
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [23:0] bus_addr = 24'h0;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic [7:0]  bus_wdata = 8'h0;
    logic [7:0]  bus_rdata;
    logic        bus_ack;
    logic        ext_timer_clock_in = 1'b0;
    logic        tape_in_line;
    logic        tape_out_line;
    logic        tape_out_oe_n;
    logic        timer_irq_out_n;
    logic [2:0]  irq_level;
    logic        zero_detect_flag;
    logic        edge_valid;
    logic        edge_ready = 1'b0;
    logic [23:0] edge_count;
    logic [23:0] v0;
    logic [7:0]  q;
    int          errors = 0;
    int          compares = 0;
    int          cyc = 0;
    int          ext_cnt = 0;
    int          n;
    logic [7:0]  ctl [4] = '{8'h83, 8'h81, 8'h87, 8'h03};
    int          lo [4] = '{45, 1500, 1595, 45};
    int          hi [4] = '{110, 3300, 3210, 110};

    ttt_timer i_dut (.sys_clk, .sys_rst, .bus_addr, .bus_wr, .bus_rd,
        .bus_wdata, .bus_rdata, .bus_ack, .ext_timer_clock_in,
        .tape_in_line, .tape_out_line, .tape_out_oe_n, .timer_irq_out_n,
        .irq_level, .zero_detect_flag, .edge_valid, .edge_ready,
        .edge_count);
    ttt_tape_model i_tape (.sys_clk, .tape_out_line, .tape_in_line);

    // clocks: system and an external timer clock at 125 kHz
    always #2.5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        ext_cnt <= (ext_cnt == 799) ? 0 : ext_cnt + 1;
        if (ext_cnt == 799) ext_timer_clock_in <= ~ext_timer_clock_in;
    end
    // cycle ceiling against hangs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            finish_test();
        end
    end

    // compare and count
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // one strobe cycle, answer checked one cycle later
    task automatic acc(input logic w, input logic [23:0] a,
                       input logic [7:0] d, input logic ea);
        @(negedge sys_clk);
        bus_wr = w;
        bus_rd = ~w;
        bus_addr = a;
        bus_wdata = d;
        @(negedge sys_clk);
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        q = bus_rdata;
        check(bus_ack, ea);
    endtask
    // register write and read at an offset
    task automatic wr(input logic [4:0] o, input logic [7:0] d);
        acc(1'b1, TIMER_BASE + 24'(o), d, 1'b1);
    endtask
    task automatic rd(input logic [4:0] o, input logic [7:0] e);
        acc(1'b0, TIMER_BASE + 24'(o), 8'h0, 1'b1);
        check(q, e);
    endtask
    task automatic set_pre(input logic [23:0] p);
        wr(OFS_PRE_HI, p[23:16]);
        wr(OFS_PRE_MID, p[15:8]);
        wr(OFS_PRE_LO, p[7:0]);
    endtask
    // bounded wait for the zero flag
    task automatic wait_flag(output int k);
        k = 0;
        while (zero_detect_flag !== 1'b1 && k < 4000) begin
            @(negedge sys_clk);
            k++;
        end
    endtask
    // one tone half: start, wait for the flag, stop
    task automatic tone_half(input int lo_c, input int hi_c);
        wr(OFS_CTRL, 8'h03);
        wait_flag(n);
        wr(OFS_CTRL, 8'h00);
        check(n >= lo_c && n <= hi_c, 1'b1);
    endtask
    task automatic finish_test();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (8) @(negedge sys_clk);
        sys_rst = 1'b0;
        check(timer_irq_out_n, 1'b1);
        check(zero_detect_flag, 1'b0);
        check(irq_level, 3'h0);
        wr(OFS_CTRL, 8'h70);
        rd(OFS_CTRL, 8'h70);
        acc(1'b0, TIMER_BASE - 24'h1, 8'h0, 1'b0);
        acc(1'b1, TIMER_LAST + 24'h1, 8'h0, 1'b0);
        acc(1'b0, TIMER_LAST, 8'h0, 1'b1);
        set_pre(24'h000002);
        rd(OFS_PRE_LO, 8'h02);
        // tick direct, tick prescaled, external direct, tick direct without irq; restarts reuse the preload
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CTRL, ctl[m]);
            wait_flag(n);
            check(n >= lo[m] && n <= hi[m], 1'b1);
            check(timer_irq_out_n, m == 3);
            check(irq_level, m == 3 ? 3'h0 : IRQ_LEVEL);
            rd(OFS_STATUS, 8'h01);
            wr(OFS_STATUS, 8'h01);
            check(zero_detect_flag, 1'b0);
            check(timer_irq_out_n, 1'b1);
            wr(OFS_CTRL, 8'h00);
        end
        // stopped snapshot of a freshly reloaded count
        set_pre(24'ha5c3e1);
        wr(OFS_CTRL, 8'h01);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_CNT_HI, 8'ha5);
        rd(OFS_CNT_MID, 8'hc3);
        rd(OFS_CNT_LO, 8'he1);
        rd(OFS_STATUS, 8'h00);
        // tape output line to the recorder
        wr(5'h01, 8'h02);
        check(tape_out_line, 1'b1);
        check(i_tape.n_out, 24'h1);
        wr(5'h01, 8'h00);
        check(tape_out_line, 1'b0);
        // send a one then a zero; half periods scaled down to ticks
        for (int b = 0; b < 2; b++) begin
            set_pre(b == 0 ? 24'd5 : 24'd10);
            wr(5'h01, 8'h02);
            tone_half(b == 0 ? 195 : 445, b == 0 ? 260 : 510);
            wr(5'h01, 8'h00);
            check(tape_out_line, 1'b0);
            tone_half(b == 0 ? 195 : 445, b == 0 ? 260 : 510);
        end
        check(i_tape.n_out, 24'd3);
        // capture periods with the reader stalled
        set_pre(24'h000fff);
        wr(OFS_CTRL, 8'h03);
        i_tape.play(4, 250);
        check(edge_valid, 1'b1);
        v0 = edge_count;
        edge_ready = 1'b1;
        @(negedge sys_clk);
        check(edge_count - v0 - 24'd9 <= 24'd2, 1'b1);
        // ones span 10 ticks, zeros 20: split midway
        check(edge_count - v0 < 24'd15, 1'b1);
        @(negedge sys_clk);
        edge_ready = 1'b0;
        check(edge_valid, 1'b0);
        finish_test();
    end
endmodule // tb_top
